// ### verilog/dbmc_pkg.sv
/*
  Shared constants for the dual full-bridge motor control and protection block:
  timing figures, cycle counts derived from the clock, leg demand codes and the
  register map of the plain register port.
  Assumes a single 25 MHz clock and synchronous inputs.
*/
`default_nettype none
package dbmc_pkg;

  // ===========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEAD_TIME_NS = 300;
  localparam int OC_FILTER_US = 10;
  localparam int RESTART_US = 50;
  // Least times round up to whole cycles
  localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_FILTER_CYC = (OC_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTART_CYC = (RESTART_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_W = $clog2(DEAD_CYC + 1);
  localparam int TMR_W = $clog2(RESTART_CYC + 1);

  // ===========================================================================
  // Leg demand codes {high side, low side}
  localparam logic [1:0] LEG_OFF = 2'h0;
  localparam logic [1:0] LEG_LOW = 2'h1;
  localparam logic [1:0] LEG_HIGH = 2'h2;

  // ===========================================================================
  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;
  localparam int CTRL_EN_POS = 0;
  localparam logic [1:0] CTRL_EN_RESET = 2'h3;
  localparam int ST_THERM_IND_POS = 0;
  localparam int ST_THERM_OFF_POS = 1;
  localparam int ST_OC_HOLD_POS = 2;
  localparam int ST_FAULT_POS = 3;
  localparam int ST_DRIVE_OK_POS = 4;

  // Overcurrent supervisor states
  typedef enum logic [2:0] {
    DBMC_OC_IDLE = 3'h1,
    DBMC_OC_FILTER = 3'h2,
    DBMC_OC_HOLD = 3'h4
  } dbmc_oc_state_t;

endpackage
`default_nettype wire

// ### verilog/dbmc_leg_if.sv
/*
  Interface between the decode logic and one half-bridge leg driver:
  the wanted leg state and the transistor gates actually switched on.
  Assumes both ends share the block clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface dbmc_leg_if;
  logic [1:0] demand;
  logic hi_on;
  logic lo_on;
  modport ctrl (output demand, input hi_on, input lo_on);
  modport leg (input demand, output hi_on, output lo_on);
endinterface
`default_nettype wire

// ### verilog/dbmc_leg_drive.sv
/*
  One half-bridge leg: follows the demanded state and inserts dead time
  whenever conduction hands between the upper and lower transistor.
  Assumes synchronous demand and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dbmc_leg_drive
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Leg connection
  dbmc_leg_if.leg leg
);

  import dbmc_pkg::*;

  logic hi_reg;
  logic lo_reg;
  logic [DEAD_W-1:0] off_cnt_reg;

  assign leg.hi_on = hi_reg;
  assign leg.lo_on = lo_reg;

  // ===========================================================================
  // Gate sequencing
  // Turn-off is immediate; turn-on waits until both gates have been off for
  // the dead time, so a change of side can never overlap
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      hi_reg <= 1'b0;
      lo_reg <= 1'b0;
      off_cnt_reg <= DEAD_W'(DEAD_CYC); // Leg starts long off
    end
    else if ((hi_reg || lo_reg) && ({hi_reg, lo_reg} != leg.demand))
    begin
      hi_reg <= 1'b0; // Leave the conducting side first
      lo_reg <= 1'b0;
      off_cnt_reg <= '0;
    end
    else if (!hi_reg && !lo_reg)
    begin
      if (off_cnt_reg >= DEAD_W'(DEAD_CYC))
      begin
        hi_reg <= (leg.demand == LEG_HIGH);
        lo_reg <= (leg.demand == LEG_LOW);
      end
      else
      begin
        off_cnt_reg <= off_cnt_reg + 1'b1; // Counted in clock cycles
      end
    end
  end

endmodule
`default_nettype wire

// ### verilog/dbmc_top.sv
/*
  Dual full-bridge brushed DC motor control and protection.
  Decodes direction, standby and speed pulse per bridge, drives the gate
  signals through dead-time leg drivers, and supervises thermal and
  overcurrent indications with timed automatic restart and a fault flag.
  Assumes host inputs and comparator indications are synchronous to ref_clk.
*/
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Speed set by speed-pulse duty per bridge
// - Pulse high drives, pulse low short brakes
// - Dead time about 300 ns per handover
// - Dead time alone makes mode changes safe
// - Thermal indication turns all transistors off
// - Thermal shutdown restarts after about 50 us
// - Thermal indication has 40 degree hysteresis
// - Any transistor overcurrent turns all off
// - Overcurrent holds off 50 us, then restarts
// - Overcurrent shutdown and restart repeat endlessly
// - Overcurrent acts only after 10 us continuous
// - Shutdown comes from comparator, not requests
// - Fault flag high during limiter or thermal
// - Fault flag returns low automatically
// - Standby low makes both outputs high impedance
module dbmc_top
#(
  parameter int NUM_BRIDGES = 2
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host control, one bit per bridge
  input wire logic [NUM_BRIDGES-1:0] dir_sel_a,
  input wire logic [NUM_BRIDGES-1:0] dir_sel_b,
  input wire logic [NUM_BRIDGES-1:0] speed_pulse,
  input wire logic [NUM_BRIDGES-1:0] standby_n,
  // Protection comparators
  input wire logic temp_above_trip,
  input wire logic temp_above_release,
  input wire logic [4*NUM_BRIDGES-1:0] oc_detect,
  // Register port
  input wire logic [dbmc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dbmc_pkg::DATA_W-1:0] reg_wr_data,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dbmc_pkg::DATA_W-1:0] reg_rd_data,
  // Gate drive, both low means high impedance
  output logic [NUM_BRIDGES-1:0] bridge_out_a_hi,
  output logic [NUM_BRIDGES-1:0] bridge_out_a_lo,
  output logic [NUM_BRIDGES-1:0] bridge_out_b_hi,
  output logic [NUM_BRIDGES-1:0] bridge_out_b_lo,
  // Status
  output logic fault_flag,
  output logic thermal_shutdown,
  output logic overcurrent_shutdown
);

  import dbmc_pkg::*;

  // ===========================================================================
  // Declarations
  logic [NUM_BRIDGES-1:0] bridge_en_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic therm_ind_reg;
  logic [TMR_W-1:0] therm_tmr_reg;
  dbmc_oc_state_t oc_state_reg;
  dbmc_oc_state_t oc_state_next;
  logic [TMR_W-1:0] oc_tmr_reg;
  logic fault_reg;
  logic oc_hold_reg;
  logic drive_ok_reg;
  logic therm_off;
  logic oc_any;

  // ===========================================================================
  // Leg demand decode
  // Dead time lives in the leg drivers, so this decode may jump straight
  // between directions and brake without an off step
  function automatic logic [1:0] leg_demand(
    input logic dsel_a,
    input logic dsel_b,
    input logic pulse,
    input logic active,
    input logic side_b
  );
    logic [1:0] result;
    result = LEG_OFF;
    if (active)
    begin
      case ({dsel_a, dsel_b})
        2'h3: result = LEG_LOW; // Short brake
        2'h2: result = pulse ? (side_b ? LEG_LOW : LEG_HIGH) : LEG_LOW;
        2'h1: result = pulse ? (side_b ? LEG_HIGH : LEG_LOW) : LEG_LOW;
        default: result = LEG_OFF; // Stop, high impedance
      endcase
    end
    return result;
  endfunction

  // Hold test shared by every flag that follows the overcurrent supervisor
  function automatic logic is_hold(input dbmc_oc_state_t st);
    return (st == DBMC_OC_HOLD);
  endfunction

  // ===========================================================================
  // Leg drivers, two per bridge
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BRIDGES; gb++)
    begin : g_bridge
      dbmc_leg_if leg_a ();
      dbmc_leg_if leg_b ();
      logic bridge_active;
      // Standby, protection and software enable all force high impedance
      assign bridge_active = standby_n[gb] && drive_ok_reg && bridge_en_reg[gb];
      // Duty of the speed pulse sets the drive-to-brake ratio
      assign leg_a.demand = leg_demand(dir_sel_a[gb], dir_sel_b[gb], speed_pulse[gb],
                                       bridge_active, 1'b0);
      assign leg_b.demand = leg_demand(dir_sel_a[gb], dir_sel_b[gb], speed_pulse[gb],
                                       bridge_active, 1'b1);
      dbmc_leg_drive u_leg_a (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .leg(leg_a.leg)
      );
      dbmc_leg_drive u_leg_b (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .leg(leg_b.leg)
      );
      assign bridge_out_a_hi[gb] = leg_a.hi_on;
      assign bridge_out_a_lo[gb] = leg_a.lo_on;
      assign bridge_out_b_hi[gb] = leg_b.hi_on;
      assign bridge_out_b_lo[gb] = leg_b.lo_on;
    end
  endgenerate

  // ===========================================================================
  // Thermal supervisor
  // The indication trips on the upper comparator and only releases once the
  // lower one, set 40 degrees below, drops; this keeps it from chattering
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      therm_ind_reg <= 1'b0;
    end
    else if (temp_above_trip)
    begin
      therm_ind_reg <= 1'b1;
    end
    else if (!temp_above_release)
    begin
      therm_ind_reg <= 1'b0;
    end
  end

  // Restart timer reloads on every trip sample and runs down afterwards
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      therm_tmr_reg <= '0;
    end
    else if (temp_above_trip)
    begin
      therm_tmr_reg <= TMR_W'(RESTART_CYC);
    end
    else if (therm_tmr_reg != '0)
    begin
      therm_tmr_reg <= therm_tmr_reg - 1'b1;
    end
  end

  assign therm_off = therm_ind_reg || (therm_tmr_reg != '0);

  // ===========================================================================
  // Overcurrent supervisor
  // Only the comparators can trip it; no host input shuts the bridges
  assign oc_any = |oc_detect; // Any single transistor counts

  always_comb
  begin
    oc_state_next = oc_state_reg;
    case (oc_state_reg)
      DBMC_OC_IDLE:
      begin
        if (oc_any)
        begin
          oc_state_next = DBMC_OC_FILTER;
        end
      end
      DBMC_OC_FILTER:
      begin
        if (!oc_any)
        begin
          oc_state_next = DBMC_OC_IDLE; // Glitch ignored
        end
        else if (oc_tmr_reg == TMR_W'(OC_FILTER_CYC - 1))
        begin
          oc_state_next = DBMC_OC_HOLD;
        end
      end
      DBMC_OC_HOLD:
      begin
        if (oc_tmr_reg == TMR_W'(RESTART_CYC - 1))
        begin
          oc_state_next = DBMC_OC_IDLE; // Restart, may trip again
        end
      end
      default: oc_state_next = DBMC_OC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      oc_state_reg <= DBMC_OC_IDLE;
    end
    else
    begin
      oc_state_reg <= oc_state_next;
    end
  end

  // One timer serves both filter and hold; it restarts on each state change
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      oc_tmr_reg <= '0;
    end
    else if (oc_state_next != oc_state_reg)
    begin
      oc_tmr_reg <= '0;
    end
    else if (oc_state_reg != DBMC_OC_IDLE)
    begin
      oc_tmr_reg <= oc_tmr_reg + 1'b1;
    end
  end

  // ===========================================================================
  // Drive permission and flags
  // Registered so every gate and flag output comes from a flip-flop; this
  // costs one cycle of shutdown latency, far inside the 10 us filter.
  // All three follow the next state, so permission, fault flag and hold
  // output change together on the edge that enters or leaves the hold

  // Drive permission; only the thermal and overcurrent supervisors may withdraw it
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      drive_ok_reg <= 1'b0;
    end
    else
    begin
      drive_ok_reg <= !therm_off && !is_hold(oc_state_next);
    end
  end

  // Fault flag clears by itself once both supervisors have released
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      fault_reg <= 1'b0;
    end
    else
    begin
      fault_reg <= therm_off || is_hold(oc_state_next);
    end
  end

  // Hold indication in its own flop so the status pin never decodes glitches
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      oc_hold_reg <= 1'b0;
    end
    else
    begin
      oc_hold_reg <= is_hold(oc_state_next);
    end
  end

  assign fault_flag = fault_reg;
  assign thermal_shutdown = therm_ind_reg;
  assign overcurrent_shutdown = oc_hold_reg;

  // ===========================================================================
  // Register port
  // Software enable per bridge; cleared bits hold that bridge in high impedance
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      bridge_en_reg <= NUM_BRIDGES'(CTRL_EN_RESET);
    end
    else if (reg_wr && (reg_addr == CTRL_OFFSET))
    begin
      bridge_en_reg <= reg_wr_data[CTRL_EN_POS +: NUM_BRIDGES];
    end
  end

  // Read data stand for exactly the cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rd_data_reg <= '0;
    end
    else if (reg_rd)
    begin
      rd_data_reg <= '0;
      case (reg_addr)
        CTRL_OFFSET: rd_data_reg[CTRL_EN_POS +: NUM_BRIDGES] <= bridge_en_reg;
        STATUS_OFFSET:
        begin
          rd_data_reg[ST_THERM_IND_POS] <= therm_ind_reg;
          rd_data_reg[ST_THERM_OFF_POS] <= therm_off;
          rd_data_reg[ST_OC_HOLD_POS] <= oc_hold_reg;
          rd_data_reg[ST_FAULT_POS] <= fault_reg;
          rd_data_reg[ST_DRIVE_OK_POS] <= drive_ok_reg;
        end
        default: rd_data_reg <= '0;
      endcase
    end
    else
    begin
      rd_data_reg <= '0;
    end
  end

  assign reg_rd_data = rd_data_reg;

endmodule
`default_nettype wire

// ### verification/dbmc_top_sva.sv
/*
  Checker for the motor control block: dead time, standby, protection
  timing and fault flag. Assumes ref_clk is the only clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dbmc_top_sva
  import dbmc_pkg::*;
#(
  parameter int NUM_BRIDGES = 2
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Host and comparators
  input wire logic [NUM_BRIDGES-1:0] standby_n,
  input wire logic temp_above_trip,
  input wire logic temp_above_release,
  input wire logic [4*NUM_BRIDGES-1:0] oc_detect,
  // Gates and status
  input wire logic [NUM_BRIDGES-1:0] bridge_out_a_hi,
  input wire logic [NUM_BRIDGES-1:0] bridge_out_a_lo,
  input wire logic [NUM_BRIDGES-1:0] bridge_out_b_hi,
  input wire logic [NUM_BRIDGES-1:0] bridge_out_b_lo,
  input wire logic fault_flag,
  input wire logic thermal_shutdown,
  input wire logic overcurrent_shutdown
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ====================
  // Run lengths; the filter run restarts in hold so each retry is timed
  int oc_run;
  int hold_cnt;
  int trip_age;
  logic any_gate;
  assign any_gate = |{bridge_out_a_hi, bridge_out_a_lo, bridge_out_b_hi, bridge_out_b_lo};
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n || !(|oc_detect) || overcurrent_shutdown)
      oc_run <= 0;
    else
      oc_run <= oc_run + 1;
    if (!reset_n || !overcurrent_shutdown)
      hold_cnt <= 0;
    else
      hold_cnt <= hold_cnt + 1;
    if (!reset_n || temp_above_trip)
      trip_age <= 0;
    else if (trip_age < 100000)
      trip_age <= trip_age + 1;
  end
  // ====================
  // Assertions
  property p_no_shoot;
    !(|(bridge_out_a_hi & bridge_out_a_lo)) && !(|(bridge_out_b_hi & bridge_out_b_lo));
  endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("both transistors of a leg on");
  property p_dead_a;
    $fell(bridge_out_a_hi[0]) |-> !bridge_out_a_lo[0] [*8];
  endproperty
  a_dead_a: assert property (p_dead_a)
    else $error("leg a handover too fast");
  property p_dead_b;
    $fell(bridge_out_b_lo[0]) |-> !bridge_out_b_hi[0] [*8];
  endproperty
  a_dead_b: assert property (p_dead_b)
    else $error("leg b handover too fast");
  property p_standby;
    !standby_n[0] |=> !bridge_out_a_hi[0] && !bridge_out_a_lo[0]
      && !bridge_out_b_hi[0] && !bridge_out_b_lo[0];
  endproperty
  a_standby: assert property (p_standby)
    else $error("bridge driven in standby");
  property p_oc_off;
    overcurrent_shutdown |-> fault_flag ##1 !any_gate;
  endproperty
  a_oc_off: assert property (p_oc_off)
    else $error("overcurrent hold not off or flag low");
  property p_therm_trip;
    temp_above_trip |=> thermal_shutdown;
  endproperty
  a_therm_trip: assert property (p_therm_trip)
    else $error("thermal trip missed");
  property p_therm_hyst;
    thermal_shutdown && temp_above_release |=> thermal_shutdown;
  endproperty
  a_therm_hyst: assert property (p_therm_hyst)
    else $error("thermal released inside hysteresis");
  property p_therm_off;
    thermal_shutdown |=> fault_flag ##1 !any_gate;
  endproperty
  a_therm_off: assert property (p_therm_off)
    else $error("thermal shutdown not off or flag low");
  property p_oc_filter;
    $rose(overcurrent_shutdown) |-> oc_run inside {[OC_FILTER_CYC-4:OC_FILTER_CYC+4]};
  endproperty
  a_oc_filter: assert property (p_oc_filter)
    else $error("overcurrent filter length wrong");
  property p_oc_hold;
    $fell(overcurrent_shutdown) |-> hold_cnt inside {[RESTART_CYC-3:RESTART_CYC+3]};
  endproperty
  a_oc_hold: assert property (p_oc_hold)
    else $error("overcurrent hold length wrong");
  property p_fault_clear;
    trip_age > RESTART_CYC + 4 && !overcurrent_shutdown && !thermal_shutdown
      && !$past(thermal_shutdown) |-> !fault_flag;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("fault flag stuck high");
endmodule
bind dbmc_top dbmc_top_sva #(.NUM_BRIDGES(NUM_BRIDGES)) i_dbmc_top_sva (
  .ref_clk(ref_clk), .reset_n(reset_n), .standby_n(standby_n),
  .temp_above_trip(temp_above_trip), .temp_above_release(temp_above_release),
  .oc_detect(oc_detect), .bridge_out_a_hi(bridge_out_a_hi),
  .bridge_out_a_lo(bridge_out_a_lo), .bridge_out_b_hi(bridge_out_b_hi),
  .bridge_out_b_lo(bridge_out_b_lo), .fault_flag(fault_flag),
  .thermal_shutdown(thermal_shutdown), .overcurrent_shutdown(overcurrent_shutdown)
);
`default_nettype wire

// ### verification/dbmc_host_model.sv
/*
  Host controller model: drives direction, speed pulse and standby.
  Assumes the caller runs in the ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dbmc_host_model
#(
  parameter int NUM_BRIDGES = 2
)
(
  // Clock
  input wire logic ref_clk,
  // Host control
  output logic [NUM_BRIDGES-1:0] dir_sel_a,
  output logic [NUM_BRIDGES-1:0] dir_sel_b,
  output logic [NUM_BRIDGES-1:0] speed_pulse,
  output logic [NUM_BRIDGES-1:0] standby_n
);
  // Power up in standby and stop so no bridge drives before software says
  initial
  begin
    dir_sel_a = '0;
    dir_sel_b = '0;
    speed_pulse = '0;
    standby_n = '0;
  end
  // Mode {dir a, dir b, pulse, standby} to all bridges, just after an edge
  task automatic set_mode(input logic [3:0] m);
    @(posedge ref_clk);
    dir_sel_a <= {NUM_BRIDGES{m[3]}};
    dir_sel_b <= {NUM_BRIDGES{m[2]}};
    speed_pulse <= {NUM_BRIDGES{m[1]}};
    standby_n <= {NUM_BRIDGES{m[0]}};
  endtask
endmodule
`default_nettype wire

// ### verification/dbmc_top_tb.sv
/*
  Testbench for the motor control block: modes, register port, overcurrent
  and thermal protection. Assumes the checker is bound to the top.
*/
`timescale 1ns/1ps
`default_nettype none
module dbmc_top_tb;
  import dbmc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] dsa, dsb, spd, stb, ahi, alo, bhi, blo;
  logic t_trip = 1'b0;
  logic t_rel = 1'b0;
  logic [7:0] oc = '0;
  logic [3:0] ra = '0;
  logic [31:0] wd = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdd;
  logic ff, ts, os;
  int error_cnt = 0;
  int checks = 0;
  logic [3:0] md [7] = '{4'hb, 4'h9, 4'h7, 4'h5, 4'hf, 4'h3, 4'ha};
  logic [3:0] ex [7] = '{4'h9, 4'h5, 4'h6, 4'h5, 4'h5, 4'h0, 4'h0};
  // ====================
  // Clock and instances
  always #20 ref_clk = ~ref_clk;
  dbmc_host_model #(.NUM_BRIDGES(2)) i_dbmc_host_model (.ref_clk(ref_clk),
    .dir_sel_a(dsa), .dir_sel_b(dsb), .speed_pulse(spd), .standby_n(stb));
  dbmc_top #(.NUM_BRIDGES(2)) i_dbmc_top (.ref_clk(ref_clk), .reset_n(reset_n),
    .dir_sel_a(dsa), .dir_sel_b(dsb), .speed_pulse(spd), .standby_n(stb),
    .temp_above_trip(t_trip), .temp_above_release(t_rel), .oc_detect(oc),
    .reg_addr(ra), .reg_wr_data(wd), .reg_wr(wr), .reg_rd(rd), .reg_rd_data(rdd),
    .bridge_out_a_hi(ahi), .bridge_out_a_lo(alo), .bridge_out_b_hi(bhi),
    .bridge_out_b_lo(blo), .fault_flag(ff), .thermal_shutdown(ts),
    .overcurrent_shutdown(os));
  // ====================
  // Tasks
  task automatic check_val(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [7:0] gates();
    return {ahi[1], alo[1], bhi[1], blo[1], ahi[0], alo[0], bhi[0], blo[0]};
  endfunction
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge ref_clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    check_val(nm, rdd, e);
  endtask
  task automatic prot(input logic [7:0] o, input logic tt, input logic tr);
    @(posedge ref_clk);
    oc <= o;
    t_trip <= tt;
    t_rel <= tr;
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ====================
  // Watchdog, about four times the expected run
  initial
  begin
    #(40 * 20000);
    error_cnt++;
    give_verdict();
  end
  // ====================
  // Main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    wt(2);
    check_val("gates", gates(), 8'h00);
    reg_write(STATUS_OFFSET, 32'h0);
    reg_write(4'hc, 32'hffffffff);
    reg_read(CTRL_OFFSET, 32'h3, "ctrl");
    reg_read(STATUS_OFFSET, 32'h10, "status");
    wt(1);
    check_val("rd idle", rdd, 32'h0);
    reg_read(4'hc, 32'h0, "unmapped");
    for (int i = 0; i < 7; i++)
    begin
      i_dbmc_host_model.set_mode(md[i]);
      wt(12);
      check_val("mode", gates(), {ex[i], ex[i]});
    end
    i_dbmc_host_model.set_mode(4'hb);
    reg_write(CTRL_OFFSET, 32'h2);
    wt(12);
    check_val("en", gates(), 8'h90);
    reg_read(CTRL_OFFSET, 32'h2, "ctrl");
    reg_write(CTRL_OFFSET, 32'h3);
    // Short glitch must be ignored
    prot(8'h01, 1'b0, 1'b0);
    wt(200);
    prot(8'h00, 1'b0, 1'b0);
    wt(5);
    check_val("oc glitch", os, 1'b0);
    prot(8'h20, 1'b0, 1'b0);
    wt(300);
    check_val("oc", os, 1'b1);
    check_val("flag", ff, 1'b1);
    check_val("gates", gates(), 8'h00);
    reg_read(STATUS_OFFSET, 32'hc, "status");
    wt(1300);
    check_val("oc", os, 1'b0);
    check_val("gates", gates(), 8'h99);
    wt(200);
    check_val("oc", os, 1'b1);
    prot(8'h00, 1'b0, 1'b0);
    wt(1300);
    check_val("flag", ff, 1'b0);
    prot(8'h00, 1'b1, 1'b1);
    wt(5);
    check_val("therm", ts, 1'b1);
    prot(8'h00, 1'b0, 1'b1);
    wt(100);
    check_val("therm", ts, 1'b1);
    check_val("gates", gates(), 8'h00);
    prot(8'h00, 1'b0, 1'b0);
    wt(5);
    check_val("therm", ts, 1'b0);
    check_val("flag", ff, 1'b1);
    wt(1300);
    check_val("flag", ff, 1'b0);
    check_val("gates", gates(), 8'h99);
    give_verdict();
  end
endmodule
`default_nettype wire
